/* File: core/frcc_timer.sv */
// free-running capture/compare timer channel with plain register port
// assumes capture inputs are synchronous to ref_clk and software keeps its side
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "frcc_cfg.svh"
// Operation
// RULE1: mode field 101 selects free run; counting begins when run bit is one.
// RULE2: each capcmp register is compare or capture by its own select bit.
// RULE3: compare exists always; capture only when the channel has capture support.
// RULE4: enabling counting inverts both timer outputs.
// RULE5: counter matching a compare register raises its irq and inverts outputs.
// RULE6: for compare value D the match effect happens when counter reaches D+1.
// RULE7: after FFFFH next count tick raises wrap irq, counter wraps to zero.
// RULE8: each wrap sets sticky wrap flag until software clears it.
// RULE9: software checks wrap flag is one before clearing it.
// RULE10: compare writes take effect immediately, no buffering.
// RULE11: valid capture edge latches counter and raises capture irq.
// RULE12: capture never clears or stops the counter.
// RULE13: live counter value is readable through count readback register.
// RULE14: software sets unused capture input edges to none.
// RULE15: shared pin functions are used one at a time by software.
// RULE16: interval software loads D-1 then adds D modulo 10000H.
// RULE17: pulse width is difference of consecutive capture reads.
// RULE18: with one wrap, width is 10000H plus new minus old.
// RULE19: with two captures, software keeps one wrap mark per register.
module frcc_timer #(
    parameter bit HAS_CAPTURE = `FRCC_CAPTURE_EN
) (
    input  wire logic                ref_clk,
    input  wire logic                reset_n,
    input  wire frcc_pkg::frcc_addr_t addr,
    input  wire logic [15:0]         wdata,
    input  wire logic                wr,
    input  wire logic                rd,
    output logic [15:0]              rdata,
    input  wire logic                capture_in0,
    input  wire logic                capture_in1,
    output logic                     timer_out0,
    output logic                     timer_out1,
    output logic [1:0]               capcmp_irq,
    output logic                     wrap_irq
);
    import frcc_pkg::*;

    logic [7:0]  timer_control_reg0_q, timer_control_reg0_d;
    logic [2:0]  mode_q, mode_d;
    logic [1:0]  sel_q, sel_d;
    logic        wrap_flag_q, wrap_flag_d;
    logic [3:0]  edge_q, edge_d;
    frcc_word_t  capcmp_q [2];
    frcc_word_t  capcmp_d [2];
    frcc_word_t  cnt_q, cnt_d;
    frcc_state_t st_q, st_d;
    logic        out0_d, out1_d;
    logic [1:0]  irq_d;
    logic        wrap_irq_d;
    logic [15:0] rdata_d;
    logic [1:0]  cin_q;
    logic [1:0]  cap_hit;
    logic [1:0]  cmp_hit;
    logic        tick;
    logic        running;
    logic        count_run_bit;
    logic        start;
    logic        wrap_ev;
    logic        armed_q, armed_d;   // set once the counter has shown a counted value

    // a capture edge of the selected kind, decoded for both inputs
    function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
        edge_hit = (sel[0] && !prev && cur) || (sel[1] && prev && !cur);
    endfunction

    assign count_run_bit = timer_control_reg0_q[`FRCC_CTL0_RUN_BIT];
    assign running = count_run_bit && (mode_q == `FRCC_MODE_FREE); // RULE1
    assign start   = (st_q == FRCC_ST_IDLE) && running;
    // the parked FFFF before the first tick is no wrap, so no overflow at start
    assign wrap_ev = tick && (st_q == FRCC_ST_RUN) && armed_q && (cnt_q == `FRCC_CNT_MAX);

    frcc_prescale u_pre (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .run     (running),
        .sel     (timer_control_reg0_q[`FRCC_CTL0_CKS_LSB +: 3]),
        .tick    (tick)
    );

    // per-unit match and capture detection
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_unit
            // compare on the current count so the effect lands as counter shows D+1
            assign cmp_hit[gi] = !sel_q[gi] && tick && (st_q == FRCC_ST_RUN)
                                 && (cnt_q == capcmp_q[gi]); // RULE5 RULE6 RULE10
            assign cap_hit[gi] = HAS_CAPTURE && sel_q[gi] && (st_q == FRCC_ST_RUN)
                                 && edge_hit(edge_q[2*gi +: 2], cin_q[gi],
                                             gi == 0 ? capture_in0 : capture_in1); // RULE3 RULE11
        end
    endgenerate

    // next-state logic for counter, registers, outputs and read port
    always_comb begin
        timer_control_reg0_d = timer_control_reg0_q;
        mode_d      = mode_q;
        sel_d       = sel_q;
        edge_d      = edge_q;
        capcmp_d[0] = capcmp_q[0];
        capcmp_d[1] = capcmp_q[1];
        cnt_d       = cnt_q;
        st_d        = st_q;
        out0_d      = timer_out0;
        out1_d      = timer_out1;
        irq_d       = 2'b00;
        wrap_irq_d  = 1'b0;
        wrap_flag_d = wrap_flag_q;
        armed_d     = armed_q;
        rdata_d     = 16'h0000;
        case (st_q)
            FRCC_ST_IDLE: begin
                cnt_d = `FRCC_CNT_IDLE;
                armed_d = 1'b0;
                if (running) begin
                    st_d   = FRCC_ST_RUN;
                    out0_d = !timer_out0; // RULE4
                    out1_d = !timer_out1; // RULE4
                end
            end
            FRCC_ST_RUN: begin
                if (!running) begin
                    st_d  = FRCC_ST_IDLE;
                    cnt_d = `FRCC_CNT_IDLE;
                    armed_d = 1'b0;
                end else if (tick) begin
                    cnt_d = cnt_q + 16'h0001; // RULE7 RULE12
                    armed_d = 1'b1; // RULE7
                end
            end
            default: st_d = FRCC_ST_IDLE;
        endcase
        if (wrap_ev) begin
            wrap_irq_d = 1'b1; // RULE7
        end
        if (|cmp_hit) begin
            out0_d = !out0_d; // RULE5
            out1_d = !out1_d; // RULE5
        end
        // software writes; the wrap flag write is a clear only
        if (wr) begin
            if (addr == `FRCC_OFS_CTL0) begin
                timer_control_reg0_d = wdata[7:0];
            end else if (addr == `FRCC_OFS_CTL1) begin
                mode_d = wdata[`FRCC_CTL1_MD_LSB +: 3];
            end else if (addr == `FRCC_OFS_OPT) begin
                sel_d = {wdata[`FRCC_OPT_CCS1_BIT], wdata[`FRCC_OPT_CCS0_BIT]}; // RULE2
                if (!wdata[`FRCC_OPT_WRAP_BIT]) begin
                    wrap_flag_d = 1'b0;
                end
            end else if (addr == `FRCC_OFS_EDGE) begin
                edge_d = wdata[3:0];
            end else if (addr == `FRCC_OFS_CCR0) begin
                capcmp_d[0] = wdata; // RULE10
            end else if (addr == `FRCC_OFS_CCR1) begin
                capcmp_d[1] = wdata; // RULE10
            end
        end
        // hardware set beats a simultaneous software clear
        if (wrap_ev) begin
            wrap_flag_d = 1'b1; // RULE8
        end
        for (int i = 0; i < 2; i++) begin
            if (cmp_hit[i] || cap_hit[i]) begin
                irq_d[i] = 1'b1;
            end
            if (cap_hit[i]) begin
                capcmp_d[i] = cnt_q; // RULE11 RULE12
            end
        end
        if (rd) begin
            if (addr == `FRCC_OFS_CTL0) begin
                rdata_d = {8'h00, timer_control_reg0_q};
            end else if (addr == `FRCC_OFS_CTL1) begin
                rdata_d = {13'h0000, mode_q};
            end else if (addr == `FRCC_OFS_OPT) begin
                rdata_d = {10'h000, sel_q, 3'h0, wrap_flag_q};
            end else if (addr == `FRCC_OFS_EDGE) begin
                rdata_d = {12'h000, edge_q};
            end else if (addr == `FRCC_OFS_CCR0) begin
                rdata_d = capcmp_q[0];
            end else if (addr == `FRCC_OFS_CCR1) begin
                rdata_d = capcmp_q[1];
            end else if (addr == `FRCC_OFS_CNT) begin
                rdata_d = cnt_q; // RULE13
            end else if (addr == `FRCC_OFS_PINS) begin
                rdata_d = {14'h0000, timer_out1, timer_out0};
            end else begin
                rdata_d = 16'h0000;
            end
        end
    end

    // registers only; all outputs come straight from flip-flops
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_control_reg0_q <= 8'h00;
            mode_q      <= 3'h0;
            sel_q       <= 2'b00;
            edge_q      <= 4'h0;
            capcmp_q[0] <= `FRCC_RST_REG;
            capcmp_q[1] <= `FRCC_RST_REG;
            cnt_q       <= `FRCC_CNT_IDLE;
            st_q        <= FRCC_ST_IDLE;
            wrap_flag_q <= 1'b0;
            timer_out0  <= 1'b0;
            timer_out1  <= 1'b0;
            capcmp_irq  <= 2'b00;
            wrap_irq    <= 1'b0;
            rdata       <= 16'h0000;
            cin_q       <= 2'b00;
            armed_q     <= 1'b0;
        end else begin
            timer_control_reg0_q <= timer_control_reg0_d;
            mode_q      <= mode_d;
            sel_q       <= sel_d;
            edge_q      <= edge_d;
            capcmp_q[0] <= capcmp_d[0];
            capcmp_q[1] <= capcmp_d[1];
            cnt_q       <= cnt_d;
            st_q        <= st_d;
            wrap_flag_q <= wrap_flag_d;
            timer_out0  <= out0_d;
            timer_out1  <= out1_d;
            capcmp_irq  <= irq_d;
            wrap_irq    <= wrap_irq_d;
            rdata       <= rdata_d;
            cin_q       <= {capture_in1, capture_in0};
            armed_q     <= armed_d;
        end
    end

    // checks
    property p_start_inv;
        @(posedge ref_clk) disable iff (!reset_n)
        start |=> (timer_out0 != $past(timer_out0)) && (timer_out1 != $past(timer_out1));
    endproperty
    a_start_inv: assert property (p_start_inv) else $error("outputs not inverted at start"); // RULE4
    property p_mode;
        @(posedge ref_clk) disable iff (!reset_n)
        (st_q == FRCC_ST_IDLE) && !(count_run_bit && mode_q == `FRCC_MODE_FREE)
            |=> st_q == FRCC_ST_IDLE;
    endproperty
    a_mode: assert property (p_mode) else $error("counter ran outside free mode"); // RULE1
    property p_match;
        @(posedge ref_clk) disable iff (!reset_n)
        cmp_hit[0] |=> capcmp_irq[0] && (cnt_q == $past(capcmp_q[0]) + 16'h0001);
    endproperty
    a_match: assert property (p_match) else $error("match irq not at D+1"); // RULE5 RULE6
    property p_match_out;
        @(posedge ref_clk) disable iff (!reset_n)
        (cmp_hit != 2'b00) && !start |=> timer_out0 != $past(timer_out0);
    endproperty
    a_match_out: assert property (p_match_out) else $error("match did not invert"); // RULE5
    property p_wrap;
        @(posedge ref_clk) disable iff (!reset_n)
        wrap_ev |=> wrap_irq && wrap_flag_q && (cnt_q == `FRCC_CNT_ZERO);
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap not handled"); // RULE7 RULE8
    property p_sticky;
        @(posedge ref_clk) disable iff (!reset_n)
        wrap_flag_q && !(wr && addr == `FRCC_OFS_OPT) |=> wrap_flag_q;
    endproperty
    a_sticky: assert property (p_sticky) else $error("wrap flag dropped"); // RULE8
    property p_cap;
        @(posedge ref_clk) disable iff (!reset_n)
        cap_hit[0] |=> capcmp_irq[0] && (capcmp_q[0] == $past(cnt_q));
    endproperty
    a_cap: assert property (p_cap) else $error("capture not latched"); // RULE11
    property p_cap_run;
        @(posedge ref_clk) disable iff (!reset_n)
        (cap_hit != 2'b00) && running && tick |=> cnt_q == $past(cnt_q) + 16'h0001;
    endproperty
    a_cap_run: assert property (p_cap_run) else $error("capture disturbed counter"); // RULE12
    property p_cnt_read;
        @(posedge ref_clk) disable iff (!reset_n)
        rd && addr == `FRCC_OFS_CNT |=> rdata == $past(cnt_q);
    endproperty
    a_cnt_read: assert property (p_cnt_read) else $error("bad count readback"); // RULE13
    property p_ccr_write;
        @(posedge ref_clk) disable iff (!reset_n)
        wr && addr == `FRCC_OFS_CCR0 && !cap_hit[0] |=> capcmp_q[0] == $past(wdata);
    endproperty
    a_ccr_write: assert property (p_ccr_write) else $error("compare write lost"); // RULE10
    property p_match1;
        @(posedge ref_clk) disable iff (!reset_n)
        cmp_hit[1] |=> capcmp_irq[1] && (cnt_q == $past(capcmp_q[1]) + 16'h0001);
    endproperty
    a_match1: assert property (p_match1) else $error("unit 1 match irq not at D+1"); // RULE5 RULE6
    property p_first_tick;
        @(posedge ref_clk) disable iff (!reset_n)
        (st_q == FRCC_ST_RUN) && running && tick && !armed_q
            |=> !wrap_irq && (cnt_q == `FRCC_CNT_ZERO);
    endproperty
    a_first_tick: assert property (p_first_tick) else $error("overflow raised at start"); // RULE7
    c_wrap:  cover property (@(posedge ref_clk) disable iff (!reset_n) wrap_ev);
    c_match: cover property (@(posedge ref_clk) disable iff (!reset_n) cmp_hit[1]);
    c_cap:   cover property (@(posedge ref_clk) disable iff (!reset_n) cap_hit[0]);
    c_start: cover property (@(posedge ref_clk) disable iff (!reset_n) start);
    c_clear: cover property (@(posedge ref_clk) disable iff (!reset_n)
                             wrap_flag_q && wr && (addr == `FRCC_OFS_OPT) && !wdata[0]);
endmodule // frcc_timer
`default_nettype wire

/* File: pkg/frcc_cfg.svh */
// register offsets, field positions, reset values and timing counts for the capture/compare timer
// assumes inclusion by bare name from the package and the core
`ifndef FRCC_CFG_SVH
`define FRCC_CFG_SVH
`define FRCC_ADDR_W        4
`define FRCC_OFS_CTL0      4'h0
`define FRCC_OFS_CTL1      4'h1
`define FRCC_OFS_OPT       4'h2
`define FRCC_OFS_EDGE      4'h3
`define FRCC_OFS_CCR0      4'h4
`define FRCC_OFS_CCR1      4'h5
`define FRCC_OFS_CNT       4'h6
`define FRCC_OFS_PINS      4'h7
`define FRCC_CTL0_RUN_BIT  7
`define FRCC_CTL0_CKS_LSB  0
`define FRCC_CTL1_MD_LSB   0
`define FRCC_OPT_WRAP_BIT  0
`define FRCC_OPT_CCS0_BIT  4
`define FRCC_OPT_CCS1_BIT  5
`define FRCC_EDGE_IN0_LSB  0
`define FRCC_EDGE_IN1_LSB  2
`define FRCC_MODE_FREE     3'h5
`define FRCC_CNT_MAX       16'hFFFF
`define FRCC_CNT_ZERO      16'h0000
`define FRCC_CNT_IDLE      16'hFFFF
`define FRCC_RST_REG       16'h0000
`define FRCC_CAPTURE_EN    1'b1
`endif

/* File: pkg/frcc_pkg.sv */
// types for the free-running capture/compare timer channel
// assumes the constants header sits beside it
`include "frcc_cfg.svh"
package frcc_pkg;
    typedef logic [15:0] frcc_word_t;
    typedef logic [`FRCC_ADDR_W-1:0] frcc_addr_t;
    typedef enum logic [1:0] {
        FRCC_EDGE_NONE = 2'b00,
        FRCC_EDGE_RISE = 2'b01,
        FRCC_EDGE_FALL = 2'b10,
        FRCC_EDGE_BOTH = 2'b11
    } frcc_edge_t;
    typedef enum logic [0:0] {
        FRCC_ST_IDLE = 1'b0,
        FRCC_ST_RUN  = 1'b1
    } frcc_state_t;
endpackage

/* File: core/frcc_prescale.sv */
// count clock divider: one-cycle enable pulse every 2**sel reference cycles
// assumes a single reference clock; sel may change at any time
`timescale 1ns/100ps
`default_nettype none
module frcc_prescale (
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       run,
    input  wire logic [2:0] sel,
    output logic            tick
);
    import frcc_pkg::*;
    logic [7:0] div_q;
    logic [7:0] div_d;
    logic       tick_d;

    // divider restarts when counting stops so the first tick follows run cleanly
    always_comb begin
        div_d  = run ? div_q + 8'h01 : 8'h00;
        tick_d = run && ((div_q & ((8'h01 << sel) - 8'h01)) == ((8'h01 << sel) - 8'h01));
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            div_q <= 8'h00;
            tick  <= 1'b0;
        end else begin
            div_q <= div_d;
            tick  <= tick_d;
        end
    end
endmodule // frcc_prescale
`default_nettype wire

/* File: verif/frcc_pins_model.sv */
// stand-in for the capture input pins and the timer output loads
// assumes the bench calls set0 just after a rising clock edge
`timescale 1ns/100ps
`default_nettype none
module frcc_pins_model (
    input  wire logic ref_clk,
    input  wire logic timer_out0,
    input  wire logic timer_out1,
    output logic      capture_in0,
    output logic      capture_in1
);
    // in1 stays quiet: its edge select is none, the shared pin is not driven twice
    initial begin
        capture_in0 = 1'b0;
        capture_in1 = 1'b0;
    end
    // level change on input 0, taken at the next rising edge
    task automatic set0(input logic v);
        capture_in0 <= v;
    endtask
endmodule // frcc_pins_model
`default_nettype wire

/* File: verif/frcc_timer_tb.sv */
// self-checking bench for the free-running capture/compare timer
// assumes one 200 MHz clock and count clock select 0, a tick every cycle
`timescale 1ns/100ps
`default_nettype none
`include "frcc_cfg.svh"
module frcc_timer_tb;
    import frcc_pkg::*;
    logic        ref_clk;
    logic        reset_n;
    frcc_addr_t  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;
    logic        capture_in0;
    logic        capture_in1;
    logic        timer_out0;
    logic        timer_out1;
    logic [1:0]  capcmp_irq;
    logic        wrap_irq;
    int          fail_count;
    int          n_compared;
    int          irq0_seen = 0;
    int          cyc = 0;

    frcc_timer i_frcc_timer (.ref_clk(ref_clk), .reset_n(reset_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .capture_in0(capture_in0),
        .capture_in1(capture_in1), .timer_out0(timer_out0), .timer_out1(timer_out1),
        .capcmp_irq(capcmp_irq), .wrap_irq(wrap_irq));
    frcc_pins_model i_frcc_pins_model (.ref_clk(ref_clk), .timer_out0(timer_out0),
        .timer_out1(timer_out1), .capture_in0(capture_in0), .capture_in1(capture_in1));

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // unit 0 events, counted to catch missing or extra captures; cyc times the stimulus
    always @(posedge ref_clk) begin
        cyc++;
        if (capcmp_irq[0] === 1'b1) irq0_seen++;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // strobes start one edge after entry, so calls never overlap
    task automatic wr_reg(input frcc_addr_t a, input logic [15:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input frcc_addr_t a, output logic [15:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // bit 0/1 unit events, bit 2 wrap; returns in the pulse cycle
    task automatic wait_irq(input int b, input int lim);
        logic [2:0] v;
        int n;
        n = 0;
        v = 3'h0;
        while (v[b] !== 1'b1 && n < lim) begin
            @(posedge ref_clk);
            #1 v = {wrap_irq, capcmp_irq};
            n++;
        end
        check({15'h0000, v[b]}, 16'h0001);
    endtask
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic t_reset;
        logic [15:0] d;
        check({11'h000, wrap_irq, capcmp_irq, timer_out1, timer_out0}, 16'h0000);
        rd_reg(`FRCC_OFS_CNT, d);
        check(d, 16'hFFFF);
        rd_reg(`FRCC_OFS_OPT, d);
        check(d, 16'h0000);
        rd_reg(4'hF, d);
        check(d, 16'h0000);
    endtask
    // run bit without the free-run mode must leave the counter parked
    task automatic t_mode;
        logic [15:0] d;
        wr_reg(`FRCC_OFS_CTL0, 16'h0080);
        repeat (3) @(posedge ref_clk);
        rd_reg(`FRCC_OFS_CNT, d);
        check(d, 16'hFFFF);
        wr_reg(`FRCC_OFS_CTL0, 16'h0000);
    endtask
    // interval of 0x20: first load D-1, then add D while running
    task automatic t_compare;
        logic [15:0] d;
        logic [1:0] o;
        wr_reg(`FRCC_OFS_CCR1, 16'h8000);
        wr_reg(`FRCC_OFS_CCR0, 16'h001F);
        wr_reg(`FRCC_OFS_CTL1, 16'h0005);
        o = {timer_out1, timer_out0};
        wr_reg(`FRCC_OFS_CTL0, 16'h0080);
        repeat (2) @(posedge ref_clk);
        #1 check({14'h0000, timer_out1, timer_out0}, {14'h0000, ~o});
        o = {timer_out1, timer_out0};
        rd_reg(`FRCC_OFS_OPT, d);
        check(d, 16'h0000);
        wait_irq(0, 100);
        check({14'h0000, timer_out1, timer_out0}, {14'h0000, ~o});
        rd_reg(`FRCC_OFS_CNT, d);
        check(d, 16'h0021);
        wr_reg(`FRCC_OFS_CCR0, 16'h003F);
        wait_irq(0, 100);
        rd_reg(`FRCC_OFS_CNT, d);
        check(d, 16'h0041);
    endtask
    // two rising edges 23 cycles apart; falling edges must be ignored
    task automatic t_capture;
        logic [15:0] c [2];
        logic [15:0] k;
        int n0;
        wr_reg(`FRCC_OFS_EDGE, 16'h0001);
        wr_reg(`FRCC_OFS_OPT, 16'h0010);
        n0 = irq0_seen;
        rd_reg(`FRCC_OFS_CNT, k);
        for (int i = 0; i < 2; i++) begin
            @(posedge ref_clk);
            i_frcc_pins_model.set0(1'b1);
            repeat (10) @(posedge ref_clk);
            i_frcc_pins_model.set0(1'b0);
            repeat (10) @(posedge ref_clk);
            rd_reg(`FRCC_OFS_CCR0, c[i]);
        end
        check(c[1] - c[0], 16'h0017);
        check(16'(irq0_seen - n0), 16'h0002);
        rd_reg(`FRCC_OFS_CNT, c[0]);
        check(c[0], k + 16'h0030);
    endtask
    // one capture before the wrap and one after; a software mark bridges the wrap
    task automatic t_wrap;
        logic [15:0] d;
        logic [15:0] c [2];
        logic [16:0] w;
        logic        soft_wrap_mark0;
        logic        soft_wrap_mark1;
        int          t [2];
        soft_wrap_mark0 = 1'b0;
        soft_wrap_mark1 = 1'b0;
        @(posedge ref_clk);
        i_frcc_pins_model.set0(1'b1);
        #1 t[0] = cyc;
        repeat (3) @(posedge ref_clk);
        i_frcc_pins_model.set0(1'b0);
        rd_reg(`FRCC_OFS_CCR0, c[0]);
        wait_irq(2, 66000);
        rd_reg(`FRCC_OFS_CNT, d);
        check(d, 16'h0001);
        rd_reg(`FRCC_OFS_OPT, d);
        check(d, 16'h0011);
        soft_wrap_mark0 = 1'b1;
        soft_wrap_mark1 = 1'b1;
        if (d[`FRCC_OPT_WRAP_BIT] === 1'b1) wr_reg(`FRCC_OFS_OPT, 16'h0010);
        rd_reg(`FRCC_OFS_OPT, d);
        check(d, 16'h0010);
        @(posedge ref_clk);
        i_frcc_pins_model.set0(1'b1);
        #1 t[1] = cyc;
        repeat (3) @(posedge ref_clk);
        i_frcc_pins_model.set0(1'b0);
        rd_reg(`FRCC_OFS_CCR0, c[1]);
        w = {1'b0, c[1]} - {1'b0, c[0]};
        if (soft_wrap_mark0) w = w + 17'h10000;
        soft_wrap_mark0 = 1'b0;
        check({15'h0000, w[16]}, 16'h0000);
        check(w[15:0], 16'(t[1] - t[0]));
    endtask

    initial begin
        reset_n = 1'b0;
        addr = '0;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        fail_count = 0;
        n_compared = 0;
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_reset();
        t_mode();
        t_compare();
        t_capture();
        t_wrap();
        finish_test();
    end
    // a full wrap is 65536 cycles; anything well past that is a hang
    initial begin
        repeat (80000) @(posedge ref_clk);
        fail_count++;
        finish_test();
    end
endmodule // frcc_timer_tb
`default_nettype wire
